/* serfe_cfg.svh */
// Constants for the video input pin front end
`ifndef SERFE_CFG_SVH
`define SERFE_CFG_SVH
`define OFS_CTRL 12'h000
`define OFS_GPO 12'h004
`define OFS_GPIO 12'h008
`define OFS_STATUS 12'h00C
`define CTRL_FILT_BIT 0
`define CTRL_EDGE_BIT 1
`define CTRL_M18_BIT 2
`define CTRL_RST 3'h1
`define GPO_VAL_LSB 0
`define GPO_EN_LSB 8
`define GPO_RST 5'h00
`define GPIO_DIR_LSB 0
`define GPIO_OUT_LSB 4
`define GPIO_IN_LSB 8
`define GPIO_RST 4'h0
`define STAT_ADDR_LSB 0
`define STAT_M18_BIT 8
`define STAT_OVF_LSB 16
`define FILT_LEN 2'd3
`define TGT_ADDR_BASE 7'h0C
`define FIFO_DEPTH 32
`define FIFO_WIDTH 29
`endif

/* serfe_pkg.sv */
// Types shared by the video input pin front end
package serfe_pkg;
	typedef logic [31:0] apb_word_t;
	typedef enum logic {EDGE_RISE, EDGE_FALL} strobe_edge_t;
	typedef enum {ADDR_WAIT, ADDR_HELD} addr_state_t;
endpackage : serfe_pkg

/* sample_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
	parameter int WIDTH = 29,
	parameter int DEPTH = 32
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset, active low
	input wire logic flush, // Synchronous empty
	input wire logic in_valid, // Write request
	output logic in_ready, // Space free
	input wire logic [WIDTH-1:0] in_data, // Write word
	output logic out_valid, // Word present
	input wire logic out_ready, // Reader takes word
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ;
		out_valid = (cnt_q != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1)) : wr_q;
		rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1)) : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end
		out_data = mem_q[rd_q];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage carries no reset to keep it plain flops
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule : sample_fifo

/* serializer_front_end.sv */
// Pixel, audio and shared-pin front end of a video serializer
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "serfe_cfg.svh"
module serializer_front_end import serfe_pkg::*; #(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic pclk, // System clock, 10 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic power_down_low_input, // Low powers the block down
	input wire logic mode_select_18bit, // Configuration pin for 18-bit mode
	input wire logic [3:0] bus_address_select_input, // Digitised divider level
	input wire logic pixel_clock_in, // Pixel strobe, sampled on pclk
	input wire logic video_data_valid, // Data-valid from the source
	input wire logic [23:0] pixel_data_in, // Parallel pixel inputs
	input wire logic audio_bit_clock_in, // Audio bit clock pin
	input wire logic audio_word_clock_in, // Audio word clock pin
	input wire logic audio_first_data_in, // Audio data A pin
	input wire logic audio_second_data_in, // Shared pin: audio B, bit 17 or output 5
	output logic [8:4] register_driven_outputs, // Output values of shared pins
	output logic [8:4] register_driven_oe, // High while a shared pin is driven
	output logic [3:0] gpio_out, // General-purpose pin output value
	output logic [3:0] gpio_oe, // High while a general-purpose pin is driven
	output logic [6:0] target_address, // Control bus target address
	output logic [`FIFO_WIDTH-1:0] link_word, // Captured word toward the link
	output logic link_valid, // Link word present
	input wire logic link_ready, // Link takes the word
	output logic serial_out_p, // Serial true leg
	output logic serial_out_n, // Serial inverted leg
	output logic synth_enable // Clock synthesiser enable
);
	logic pd_active;
	logic [2:0] ctrl_q, ctrl_d;
	logic [4:0] gpo_val_q, gpo_val_d, gpo_en_q, gpo_en_d;
	logic [3:0] gpio_dir_q, gpio_dir_d, gpio_o_q, gpio_o_d;
	logic [7:0] ovf_q, ovf_d;
	logic filter_en, mode18;
	strobe_edge_t edge_sel;
	logic apb_wr, apb_rd, hit;
	logic [31:0] rd_mux;

	// Powered down means control state held at reset
	assign pd_active = !power_down_low_input;
	assign filter_en = ctrl_q[`CTRL_FILT_BIT];
	assign edge_sel = strobe_edge_t'(ctrl_q[`CTRL_EDGE_BIT]);
	assign mode18 = mode_select_18bit | ctrl_q[`CTRL_M18_BIT];

	// Zero-wait slave: every access finishes in its first access cycle
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;

	always_comb begin
		hit = 1'b1;
		rd_mux = '0;
		case (paddr)
			`OFS_CTRL: rd_mux[2:0] = ctrl_q;
			`OFS_GPO: begin
				rd_mux[`GPO_VAL_LSB +: 5] = gpo_val_q;
				rd_mux[`GPO_EN_LSB +: 5] = gpo_en_q;
			end
			`OFS_GPIO: begin
				rd_mux[`GPIO_DIR_LSB +: 4] = gpio_dir_q;
				rd_mux[`GPIO_OUT_LSB +: 4] = gpio_o_q;
				rd_mux[`GPIO_IN_LSB +: 4] = {pixel_data_in[9:8], pixel_data_in[1:0]};
			end
			`OFS_STATUS: begin
				rd_mux[`STAT_ADDR_LSB +: 7] = target_address;
				rd_mux[`STAT_M18_BIT] = mode18;
				rd_mux[`STAT_OVF_LSB +: 8] = ovf_q;
			end
			default: hit = 1'b0;
		endcase
		prdata = apb_rd ? rd_mux : '0;
		pslverr = psel && penable && !hit;
	end

	logic fifo_in_ready, push;
	logic pix_prev_q, strobe;
	always_comb begin
		ctrl_d = ctrl_q;
		gpo_val_d = gpo_val_q;
		gpo_en_d = gpo_en_q;
		gpio_dir_d = gpio_dir_q;
		gpio_o_d = gpio_o_q;
		ovf_d = ovf_q;
		if (apb_wr) begin
			case (paddr)
				`OFS_CTRL: ctrl_d = pwdata[2:0];
				`OFS_GPO: begin
					gpo_val_d = pwdata[`GPO_VAL_LSB +: 5];
					gpo_en_d = pwdata[`GPO_EN_LSB +: 5];
				end
				`OFS_GPIO: begin
					gpio_dir_d = pwdata[`GPIO_DIR_LSB +: 4];
					gpio_o_d = pwdata[`GPIO_OUT_LSB +: 4];
				end
				default: ;
			endcase
		end
		// A strobe lost to a full FIFO is counted, saturating
		if (strobe && !fifo_in_ready && !pd_active && ovf_q != 8'hFF) begin
			ovf_d = ovf_q + 8'h01;
		end
		if (pd_active) begin
			ctrl_d = `CTRL_RST;
			gpo_val_d = `GPO_RST;
			gpo_en_d = `GPO_RST;
			gpio_dir_d = `GPIO_RST;
			gpio_o_d = `GPIO_RST;
			ovf_d = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RST;
			gpo_val_q <= `GPO_RST;
			gpo_en_q <= `GPO_RST;
			gpio_dir_q <= `GPIO_RST;
			gpio_o_q <= `GPIO_RST;
			ovf_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			gpo_val_q <= gpo_val_d;
			gpo_en_q <= gpo_en_d;
			gpio_dir_q <= gpio_dir_d;
			gpio_o_q <= gpio_o_d;
			ovf_q <= ovf_d;
		end
	end

	assign strobe = (edge_sel == EDGE_FALL) ? (pix_prev_q && !pixel_clock_in)
		: (!pix_prev_q && pixel_clock_in);

	// Data-valid filter state
	logic de_q, de_d, last_q, last_d;
	logic [1:0] run_q, run_d;
	always_comb begin
		de_d = de_q;
		last_d = last_q;
		run_d = run_q;
		if (strobe) begin
			if (video_data_valid != last_q) begin
				last_d = video_data_valid;
				run_d = 2'd1;
			end else if (run_q < `FILT_LEN) begin
				run_d = run_q + 2'd1;
			end
			if (filter_en) begin
				de_d = (run_d == `FILT_LEN) ? last_d : de_q;
			end else begin
				de_d = video_data_valid;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_prev_q <= 1'b0;
			de_q <= 1'b0;
			last_q <= 1'b0;
			run_q <= '0;
		end else begin
			pix_prev_q <= pixel_clock_in;
			de_q <= de_d;
			last_q <= last_d;
			run_q <= run_d;
		end
	end

	// Shared pin steering; bit 17 is free only outside 18-bit mode
	logic [23:0] din_m;
	logic [3:0] gpio_act;
	logic [`FIFO_WIDTH-1:0] push_word;
	always_comb begin
		register_driven_outputs = gpo_val_q;
		register_driven_oe = gpo_en_q;
		if (mode18) begin
			register_driven_oe[5] = 1'b0;
		end
		gpio_act = mode18 ? gpio_dir_q : 4'h0;
		gpio_oe = gpio_act;
		gpio_out = gpio_o_q;
		din_m = pixel_data_in;
		din_m[17] = pixel_data_in[17] & !mode18 & !register_driven_oe[5];
		din_m[16] = pixel_data_in[16] & !register_driven_oe[4];
		din_m[9] = pixel_data_in[9] & !gpio_act[3];
		din_m[8] = pixel_data_in[8] & !gpio_act[2];
		din_m[1] = pixel_data_in[1] & !gpio_act[1];
		din_m[0] = pixel_data_in[0] & !gpio_act[0];
		push_word = {de_d, din_m,
			audio_bit_clock_in & !register_driven_oe[8],
			audio_word_clock_in & !register_driven_oe[7],
			audio_first_data_in & !register_driven_oe[6],
			audio_second_data_in & mode18};
	end

	assign push = strobe && !pd_active;

	sample_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(pd_active),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(link_valid),
		.out_ready(link_ready),
		.out_data(link_word)
	);

	logic sp_q, sp_d, sn_q, sn_d, syn_q, syn_d;
	always_comb begin
		syn_d = !pd_active;
		sp_d = pd_active ? 1'b1 : link_word[0];
		sn_d = pd_active ? 1'b1 : !link_word[0];
	end

	// Address level is caught once after reset or power-down release
	addr_state_t as_q, as_d;
	logic [6:0] addr_q, addr_d;
	always_comb begin
		as_d = as_q;
		addr_d = addr_q;
		case (as_q)
			ADDR_WAIT: begin
				if (!pd_active) begin
					addr_d = `TGT_ADDR_BASE + {3'h0, bus_address_select_input};
					as_d = ADDR_HELD;
				end
			end
			ADDR_HELD: begin
				if (pd_active) begin
					as_d = ADDR_WAIT;
				end
			end
			default: as_d = ADDR_WAIT;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= 1'b1;
			sn_q <= 1'b1;
			syn_q <= 1'b0;
			as_q <= ADDR_WAIT;
			addr_q <= `TGT_ADDR_BASE;
		end else begin
			sp_q <= sp_d;
			sn_q <= sn_d;
			syn_q <= syn_d;
			as_q <= as_d;
			addr_q <= addr_d;
		end
	end
	assign serial_out_p = sp_q;
	assign serial_out_n = sn_q;
	assign synth_enable = syn_q;
	assign target_address = addr_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_de_min_run: assert property (strobe && filter_en && de_d != de_q |-> run_d == 2'd3)
		else $error("data-valid forwarded before three strobes");
	a_de_pass: assert property (strobe && !filter_en |=> de_q == $past(video_data_valid))
		else $error("unfiltered data-valid not forwarded");
	a_strobe_edge: assert property ($rose(pixel_clock_in) && edge_sel == EDGE_FALL |-> !strobe)
		else $error("strobe on wrong edge");
	a_audio_gpo: assert property (register_driven_oe[8] && push |-> !push_word[3])
		else $error("audio clock captured while pin is an output");
	a_second_audio: assert property (push && !mode18 |-> !push_word[0])
		else $error("second audio captured outside 18-bit mode");
	a_gpio_mode: assert property (!mode18 |-> gpio_oe == 4'h0)
		else $error("general-purpose pin driven outside 18-bit mode");
	a_pd_legs: assert property (pd_active |=> serial_out_p && serial_out_n && !synth_enable)
		else $error("serial legs not high in power-down");
	a_pd_regs: assert property (pd_active |=> ctrl_q == 3'h1 && gpo_en_q == 5'h00)
		else $error("control registers not reset in power-down");
	a_din_mask: assert property (push && gpio_act[0] |-> !push_word[4])
		else $error("data bit captured while pin is general-purpose");
	a_addr_load: assert property (as_q == ADDR_WAIT && !pd_active
		|=> target_address == 7'h0C + {3'h0, $past(bus_address_select_input)})
		else $error("target address not taken from select level");

	c_pulse_pass: cover property (strobe && filter_en && de_d && !de_q);
	c_short_drop: cover property (strobe && filter_en && run_d == 2'd1 && last_q && !de_q);
	c_fifo_full: cover property (strobe && !fifo_in_ready);
	c_pd_entry: cover property ($fell(power_down_low_input));
endmodule : serializer_front_end

/* video_source.sv */
// Behavioural upstream video source driving the pixel-side pins
`timescale 1ns/100ps
module video_source (
	input wire logic pclk, // System clock
	output logic pix, // Pixel strobe
	output logic valid, // Data-valid level
	output logic [23:0] px, // Pixel data
	output logic [3:0] au // Bit clock, word clock, data A, data B
);
	int cyc = 0;
	int t1 = -200;
	int t2 = -200;
	initial begin
		pix = 1'b0;
		valid = 1'b0;
		px = 24'h0;
		au = 4'h0;
	end
	always @(posedge pclk) begin
		cyc++;
	end
	// Strobe stands still between pixels; released data falls to the pull-down level
	task send(input logic fall, input logic v, input logic [23:0] d, input logic [3:0] a);
		if (v !== valid) begin
			while (cyc - t2 < 132) @(posedge pclk);
			t2 = t1;
			t1 = cyc;
		end
		@(posedge pclk);
		pix <= fall;
		valid <= v;
		px <= d;
		au <= a;
		repeat (2) @(posedge pclk);
		pix <= ~fall;
		repeat (2) @(posedge pclk);
		px <= 24'h0;
		au <= 4'h0;
	endtask : send
endmodule : video_source

/* serializer_video_input_pin_front_end_bench.sv */
// Self-checking bench for the serializer front end
`timescale 1ns/100ps
`include "serfe_cfg.svh"
module serializer_video_input_pin_front_end_bench;
	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] outs;
		logic pin;
		logic [23:0] d;
		logic [3:0] a;
		logic v;
		logic [4:0] oe;
		logic [28:0] w;
	} row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic power_down_n = 1'b1;
	logic m18_pin = 1'b0;
	logic [3:0] addr_lvl = 4'h0;
	logic link_ready = 1'b0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, link_valid, serial_out_p, serial_out_n, synth_enable, pix, valid;
	logic [8:4] outs_v, outs_oe;
	logic [3:0] gpio_out, gpio_oe, au;
	logic [6:0] target_address;
	logic [28:0] link_word, w;
	logic [23:0] px;
	logic [8:0] pat = 9'b111011000;
	logic [8:0] fexp = 9'b100000000;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	row_t rows [5];
	always #50 pclk = ~pclk;
	video_source src (.pclk(pclk), .pix(pix), .valid(valid), .px(px), .au(au));
	serializer_front_end dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_down_low_input(power_down_n), .mode_select_18bit(m18_pin),
		.bus_address_select_input(addr_lvl), .pixel_clock_in(pix), .video_data_valid(valid),
		.pixel_data_in(px), .audio_bit_clock_in(au[3]), .audio_word_clock_in(au[2]),
		.audio_first_data_in(au[1]), .audio_second_data_in(au[0]),
		.register_driven_outputs(outs_v), .register_driven_oe(outs_oe), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .target_address(target_address), .link_word(link_word),
		.link_valid(link_valid), .link_ready(link_ready), .serial_out_p(serial_out_p),
		.serial_out_n(serial_out_n), .synth_enable(synth_enable));
	task print_verdict();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	// Holds the request until pready is seen high at a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0);
		chk(r, x, m);
	endtask : rd
	// Waits an edge first so a word just taken is not seen again
	task pop();
		do begin
			@(posedge pclk);
		end while (link_valid !== 1'b1);
		link_ready <= 1'b1;
		@(posedge pclk);
		w = link_word;
		link_ready <= 1'b0;
	endtask : pop
	task done(input string s);
		$display("test %s done", s);
	endtask : done
	initial begin
		rows[0] = '{32'h0, 32'h0, 1'b0, 24'hFF_FFFF, 4'hF, 1'b1, 5'h0, 29'h1FFF_FFFE};
		rows[1] = '{32'h2, 32'h0, 1'b0, 24'h12_3456, 4'h5, 1'b0, 5'h0, 29'h0123_4564};
		rows[2] = '{32'h0, 32'h1F15, 1'b0, 24'hFF_FFFF, 4'hF, 1'b1, 5'h1F, 29'h1FCF_FFF0};
		rows[3] = '{32'h4, 32'h0, 1'b0, 24'hFF_FFFF, 4'hF, 1'b1, 5'h0, 29'h1FDF_FFFF};
		rows[4] = '{32'h0, 32'h0200, 1'b1, 24'hFF_FFFF, 4'hF, 1'b1, 5'h0, 29'h1FDF_FFFF};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFS_CTRL, 32'h1, "ctrl reset");
		rd(`OFS_GPO, 32'h0, "outputs reset");
		rd(`OFS_STATUS, 32'h000C, "status reset");
		rd(12'h010, 32'h0, "unmapped read");
		chk(e, 1'b1, "unmapped error");
		done("reset");
		for (int i = 0; i < 5; i++) begin
			m18_pin <= rows[i].pin;
			apb(1'b1, `OFS_CTRL, rows[i].ctrl);
			apb(1'b1, `OFS_GPO, rows[i].outs);
			src.send(rows[i].ctrl[1], rows[i].v, rows[i].d, rows[i].a);
			pop();
			chk(w, rows[i].w, "row word");
			chk(outs_v, rows[i].outs[4:0], "row outputs");
			chk(outs_oe, rows[i].oe, "row enables");
		end
		done("rows");
		m18_pin <= 1'b0;
		apb(1'b1, `OFS_GPIO, 32'h00AF);
		@(posedge pclk);
		chk(gpio_oe, 4'h0, "gpio off outside 18-bit");
		apb(1'b1, `OFS_CTRL, 32'h4);
		@(posedge pclk);
		chk({gpio_oe, gpio_out}, 8'hFA, "gpio in 18-bit");
		src.send(1'b0, 1'b1, 24'hFF_FFFF, 4'hF);
		pop();
		chk(w, 29'h1FDF_CFCF, "gpio data bits masked");
		done("gpio");
		apb(1'b1, `OFS_CTRL, 32'h1);
		for (int i = 0; i < 9; i++) begin
			src.send(1'b0, pat[i], 24'h0, 4'h0);
			pop();
			if (i > 2) chk(w[28], fexp[i], "filtered valid");
		end
		done("filter");
		// Far side stalls while the buffer fills past its depth
		for (int i = 0; i < 34; i++) src.send(1'b0, 1'b1, 24'(i), 4'h0);
		rd(`OFS_STATUS, 32'h0002_000C, "overflow count");
		for (int i = 0; i < 32; i++) begin
			pop();
			chk(w[27:4], i, "buffer order");
		end
		repeat (2) @(posedge pclk);
		chk(link_valid, 1'b0, "buffer empty");
		done("buffer");
		apb(1'b1, `OFS_GPO, 32'h1F1F);
		addr_lvl <= 4'h5;
		power_down_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({serial_out_p, serial_out_n, synth_enable}, 3'b110, "powered down");
		chk(outs_oe, 5'h0, "enables held");
		apb(1'b1, `OFS_CTRL, 32'h4);
		rd(`OFS_CTRL, 32'h1, "ctrl held");
		power_down_n <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(synth_enable, 1'b1, "running");
		chk(target_address, 7'h11, "address");
		rd(`OFS_STATUS, 32'h0011, "status after wake");
		done("power");
		print_verdict();
	end
endmodule : serializer_video_input_pin_front_end_bench
